//--- rtl/edge_count_conditional_reset.v
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "cond_reset_regs.vh"
// Functional notes
// RULE_01 - after the set number of counted edges, reset the target feature
// RULE_02 - feature index code 12 selects conditional reset
// RULE_03 - enable register: 0 turns off, 1 turns on
// RULE_04 - option bit 0: 1 counts rising, 0 counts falling edges
// RULE_05 - option bit 2 set: reset only once; clear: every n edges
// RULE_06 - software writes zero to bit 1 and other unused option bits
// RULE_07 - edges_per_reset holds edge count needed per reset event
// RULE_08 - target_channel holds channel whose count is cleared
// RULE_09 - reset event sets the target's accumulated count to zero
// RULE_10 - current_count register returns the running edge count
// RULE_11 - no run-time updates; settings latched at enable
// RULE_12 - software disables feature before configuring, then re-enables
// RULE_13 - works without any clock-source timer
// RULE_14 - far side keeps aggregate edge rate within limits
// RULE_15 - edges of both polarities are serviced
// RULE_16 - edge sets pending flag; service completion clears it
// RULE_17 - service lasts up to 14 us, not preempted by another edge
// RULE_18 - edge arriving while pending or in service is lost
// RULE_19 - in repeated mode, count restarts from zero after each reset
module edge_count_conditional_reset (
  input wire hclk, // system clock, 50 MHz
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write strobe
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready in
  output wire hreadyout, // slave ready
  output wire hresp, // always okay
  output reg [31:0] hrdata, // read data
  input wire pin_in, // watched digital input
  output reg target_clear, // one-cycle clear pulse to target feature
  output reg [31:0] target_sel // channel of the cleared feature
);

  // software-visible registers
  reg feature_enable_r;
  reg [31:0] feature_index_r;
  reg [31:0] reset_options_r;
  reg [31:0] edges_per_reset_r;
  reg [31:0] target_channel_r;
  reg [31:0] current_count_r;
  // active copies, taken when the feature is enabled
  reg act_rising_r;
  reg act_single_r;
  reg [31:0] act_edges_r;
  reg [31:0] act_target_r;
  reg single_done_r;

  // pin synchroniser and settled level
  reg sync1_r, sync2_r, sync3_r, pin_state_r;
  reg pin_valid_r;
  reg [2:0] warm_r;

  // pending flag and service routine timer
  reg pending_r;
  reg pending_level_r;
  reg busy_r;
  reg [9:0] svc_cnt_r;
  reg svc_level_r;

  // bus data phase
  reg wr_pend_r;
  reg [11:0] wr_addr_r;

  localparam integer SVC_LAST_I = `SERVICE_CYCLES - 1;
  localparam [9:0] SVC_LAST = SVC_LAST_I[9:0];

  wire active = feature_enable_r && (feature_index_r == `IDX_COND_RESET); // [RULE_02] [RULE_03]
  wire addr_ph = hsel && hready && htrans[1];
  wire stable_chg = pin_valid_r && (sync2_r == sync3_r) && (sync3_r != pin_state_r);
  wire [31:0] count_inc = current_count_r + 32'h0000_0001;
  wire [31:0] goal = (act_edges_r == 32'h0000_0000) ? 32'h0000_0001 : act_edges_r;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // three-stage input synchroniser on the watched pin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // settled level; first real sample is taken silently, so no false edge after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm_r <= 3'h0;
      pin_state_r <= 1'b0;
      pin_valid_r <= 1'b0;
    end else begin
      warm_r <= {warm_r[1:0], 1'b1};
      if (warm_r[2] && (sync2_r == sync3_r)) begin
        pin_state_r <= sync3_r;
        pin_valid_r <= 1'b1;
      end
    end
  end

  // edge of either polarity accepted only when idle; later ones are lost
  wire take_edge = active && stable_chg && !pending_r && !busy_r; // [RULE_15] [RULE_18]
  // service starts the cycle after the flag rises
  wire svc_start = active && pending_r && !busy_r;
  // last cycle of the service routine
  wire svc_done = active && busy_r && (svc_cnt_r == SVC_LAST);

  // pending flag: set by an accepted edge, cleared when service completes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_r <= 1'b0;
    end else if (!active) begin
      pending_r <= 1'b0;
    end else if (take_edge) begin
      pending_r <= 1'b1; // [RULE_16]
    end else if (svc_done) begin
      pending_r <= 1'b0; // [RULE_16]
    end
  end

  // pin level that raised the flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_level_r <= 1'b0;
    end else if (take_edge) begin
      pending_level_r <= sync3_r;
    end
  end

  // service routine runs to completion unless the feature is switched off; no other edge can start one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
    end else if (!active) begin
      busy_r <= 1'b0;
    end else if (svc_start) begin
      busy_r <= 1'b1; // [RULE_17]
    end else if (svc_done) begin
      busy_r <= 1'b0; // [RULE_17]
    end
  end

  // service timer counts the cycles of one routine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_cnt_r <= 10'h000;
    end else if (!active || svc_start) begin
      svc_cnt_r <= 10'h000;
    end else if (busy_r && !svc_done) begin
      svc_cnt_r <= svc_cnt_r + 10'h001;
    end
  end

  // level being serviced, held against the selected polarity at the end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_level_r <= 1'b0;
    end else if (svc_start) begin
      svc_level_r <= pending_level_r;
    end
  end

  wire counted = svc_done && (svc_level_r == act_rising_r) && !single_done_r; // [RULE_04]

  // reset event: the counted edge that completes a group of n edges
  wire reaching = counted && (count_inc >= goal); // [RULE_01] [RULE_07]
  // one strobe per register, decoded from the latched data-phase address
  reg wr_enable;
  reg wr_index;
  reg wr_options;
  reg wr_edges;
  reg wr_target;

  // address phase is remembered so the write lands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_addr_r <= haddr[11:0];
      end
    end
  end

  // write address decode; unmapped and read-only offsets get no strobe
  always @* begin
    wr_enable = 1'b0;
    wr_index = 1'b0;
    wr_options = 1'b0;
    wr_edges = 1'b0;
    wr_target = 1'b0;
    if (!wr_pend_r) begin
      wr_enable = 1'b0;
    end else if (wr_addr_r == `OFS_FEATURE_ENABLE) begin
      wr_enable = 1'b1;
    end else if (wr_addr_r == `OFS_FEATURE_INDEX) begin
      wr_index = 1'b1;
    end else if (wr_addr_r == `OFS_RESET_OPTIONS) begin
      wr_options = 1'b1;
    end else if (wr_addr_r == `OFS_EDGES_PER_RESET) begin
      wr_edges = 1'b1;
    end else if (wr_addr_r == `OFS_TARGET_CHANNEL) begin
      wr_target = 1'b1;
    end
  end

  // enable written from off to on: the only moment settings are taken
  wire arm = wr_enable && hwdata[0] && !feature_enable_r; // [RULE_11]

  // feature enable bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feature_enable_r <= 1'b0;
    end else if (wr_enable) begin
      feature_enable_r <= hwdata[0]; // [RULE_03]
    end
  end

  // feature select code; only the conditional reset code activates the block
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feature_index_r <= `RST_WORD;
    end else if (wr_index) begin
      feature_index_r <= hwdata; // [RULE_02]
    end
  end

  // option bits are stored whole; unused bits read back as written
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_options_r <= `RST_WORD;
    end else if (wr_options) begin
      reset_options_r <= hwdata;
    end
  end

  // edges needed per reset event
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edges_per_reset_r <= `RST_WORD;
    end else if (wr_edges) begin
      edges_per_reset_r <= hwdata;
    end
  end

  // channel number of the feature to be cleared
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_channel_r <= `RST_WORD;
    end else if (wr_target) begin
      target_channel_r <= hwdata;
    end
  end

  // active copies of the settings; no timer is needed to run from them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_rising_r <= 1'b0;
      act_single_r <= 1'b0;
      act_edges_r <= `RST_WORD;
      act_target_r <= `RST_WORD;
    end else if (arm) begin
      act_rising_r <= reset_options_r[`OPT_RISING_BIT]; // [RULE_04]
      act_single_r <= reset_options_r[`OPT_SINGLE_BIT]; // [RULE_05]
      act_edges_r <= edges_per_reset_r; // [RULE_07]
      act_target_r <= target_channel_r; // [RULE_08] [RULE_13]
    end
  end

  // single-reset mode stops after its first reset until the next switch-on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_done_r <= 1'b0;
    end else if (arm) begin
      single_done_r <= 1'b0;
    end else if (reaching && act_single_r) begin
      single_done_r <= 1'b1; // [RULE_05]
    end
  end

  // running edge count; restarts at switch-on and after each repeated reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_count_r <= `RST_WORD;
    end else if (arm) begin
      current_count_r <= `RST_WORD;
    end else if (reaching && !act_single_r) begin
      current_count_r <= `RST_WORD; // [RULE_19]
    end else if (counted) begin
      current_count_r <= count_inc; // [RULE_10]
    end
  end

  // clear pulse lasts one cycle; the channel number holds after it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_clear <= 1'b0;
      target_sel <= `RST_WORD;
    end else begin
      target_clear <= reaching; // [RULE_01] [RULE_09]
      if (reaching) begin
        target_sel <= act_target_r; // [RULE_08]
      end
    end
  end

  reg [31:0] hrdata_nxt;
  // read mux, one word per offset; unmapped offsets read zero
  always @* begin
    hrdata_nxt = `RST_WORD;
    if (haddr[11:0] == `OFS_FEATURE_ENABLE) begin
      hrdata_nxt = {31'h0000_0000, feature_enable_r};
    end else if (haddr[11:0] == `OFS_FEATURE_INDEX) begin
      hrdata_nxt = feature_index_r;
    end else if (haddr[11:0] == `OFS_RESET_OPTIONS) begin
      hrdata_nxt = reset_options_r;
    end else if (haddr[11:0] == `OFS_EDGES_PER_RESET) begin
      hrdata_nxt = edges_per_reset_r;
    end else if (haddr[11:0] == `OFS_TARGET_CHANNEL) begin
      hrdata_nxt = target_channel_r;
    end else if (haddr[11:0] == `OFS_CURRENT_COUNT) begin
      hrdata_nxt = current_count_r; // [RULE_10]
    end else if (haddr[11:0] == `OFS_PIN_STATUS) begin
      hrdata_nxt = {28'h000_0000, single_done_r, busy_r, pending_r, pin_state_r};
    end else begin
      hrdata_nxt = `RST_WORD;
    end
  end

  // read data registered in address phase, valid through the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `RST_WORD;
    end else if (addr_ph && !hwrite) begin
      hrdata <= hrdata_nxt; // [RULE_10]
    end
  end

endmodule

//--- rtl/cond_reset_regs.vh
`ifndef COND_RESET_REGS_VH
`define COND_RESET_REGS_VH
// register byte offsets
`define OFS_FEATURE_ENABLE 12'h000
`define OFS_FEATURE_INDEX 12'h004
`define OFS_RESET_OPTIONS 12'h008
`define OFS_EDGES_PER_RESET 12'h00C
`define OFS_TARGET_CHANNEL 12'h010
`define OFS_CURRENT_COUNT 12'h014
`define OFS_PIN_STATUS 12'h018
// field positions
`define OPT_RISING_BIT 0
`define OPT_SINGLE_BIT 2
// feature select code for this function
`define IDX_COND_RESET 32'h0000_000C
// reset values
`define RST_WORD 32'h0000_0000
// timing: service time and clock period
`define SERVICE_NS 14000
`define CLK_NS 20
`define SERVICE_CYCLES (`SERVICE_NS / `CLK_NS)
`endif

//--- testbench/ecr_props.sv
`timescale 1ns/10ps
module ecr_props (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write strobe
  input wire hreadyout, // slave ready
  input wire hresp, // response
  input wire [31:0] hrdata, // read data
  input wire pin_in, // watched pin
  input wire target_clear, // clear pulse
  input wire [31:0] target_sel // cleared channel
);
  reg [9:0] gap_r;
  reg [7:0] edges_r;
  reg pin_r;
  reg seen_r;
  wire rd_ap = hsel & htrans[1] & ~hwrite;
  // cycles since the last clear and real pin changes since the last clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 10'h3ff;
      edges_r <= 8'h00;
      pin_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      pin_r <= pin_in;
      seen_r <= 1'b1;
      gap_r <= target_clear ? 10'h000 : gap_r + {9'h000, gap_r != 10'h3ff};
      edges_r <= target_clear ? 8'h00 :
        edges_r + {7'h00, seen_r && (pin_r != pin_in) && edges_r != 8'hff};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_ap;
    rd_ap && hreadyout;
  endsequence
  sequence s_unmap_rd;
    s_rd_ap ##0 (haddr[11:0] == 12'h01c);
  endsequence
  AST_READY: assert property (hreadyout) else $error("hreadyout low");
  AST_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  AST_PULSE: assert property (target_clear |=> !target_clear [*8])
    else $error("clear pulse too long");
  AST_SEL: assert property ($changed(target_sel) |-> target_clear)
    else $error("target_sel moved without clear");
  AST_UNMAP: assert property (s_unmap_rd |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!rd_ap |=> $stable(hrdata))
    else $error("hrdata moved without read");
  AST_GAP: assert property (target_clear |-> gap_r >= 10'h2b0)
    else $error("clears closer than service time");
  AST_EDGE: assert property (target_clear |-> edges_r != 8'h00)
    else $error("clear without any pin edge");
endmodule
bind edge_count_conditional_reset ecr_props ecr_props_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .target_clear(target_clear),
  .target_sel(target_sel));

//--- testbench/pin_source.sv
`timescale 1ns/10ps
module pin_source (
  input wire hclk, // sampling clock
  output reg pin_in // driven pin level
);
  initial pin_in = 1'b1;
  // set a level after an edge, then hold it; long holds keep the edge rate low
  task drive(input logic v, input int hold);
    begin
      @(posedge hclk);
      pin_in <= v;
      repeat (hold) @(posedge hclk);
    end
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
  reg hclk, hresetn, hwrite;
  reg [31:0] haddr, hwdata, rv;
  reg [1:0] htrans;
  wire hreadyout, hresp, pin_in, target_clear;
  wire [31:0] hrdata, target_sel;
  integer n_fail, n_compared, n_clr, c0, i;
  edge_count_conditional_reset edge_count_conditional_reset_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .target_clear(target_clear),
    .target_sel(target_sel));
  pin_source pin_source_inst (.hclk(hclk), .pin_in(pin_in));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // count clear pulses seen
  always @(posedge hclk) if (target_clear === 1'b1) n_clr = n_clr + 1;
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      haddr <= a; hwrite <= w; htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
    end
  endtask
  task cfg(input [31:0] opt, input [31:0] n, input [31:0] tg);
    begin
      xfer(1, 12'h000, 32'h0000_0000);
      xfer(1, 12'h004, 32'h0000_000c);
      xfer(1, 12'h008, opt);
      xfer(1, 12'h00c, n);
      xfer(1, 12'h010, tg);
      xfer(1, 12'h000, 32'h0000_0001);
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        xfer(0, 4 * i, 0);
        chk("reset word", (i == 6) ? 32'h0000_0001 : 32'h0000_0000, rv);
      end
      cfg(32'h0000_0000, 32'h0000_0002, 32'h0000_0005);
      xfer(0, 12'h004, 0);
      chk("feature_index", 32'h0000_000c, rv);
      xfer(0, 12'h00c, 0);
      chk("edges_per_reset", 32'h0000_0002, rv);
      $display("test regs done");
    end
  endtask
  task t_repeat;
    begin
      c0 = n_clr;
      pin_source_inst.drive(0, 800);
      pin_source_inst.drive(1, 800);
      xfer(0, 12'h014, 0);
      chk("count after fall", 32'h0000_0001, rv);
      pin_source_inst.drive(0, 800);
      chk("clears", c0 + 1, n_clr);
      chk("target_sel", 32'h0000_0005, target_sel);
      xfer(0, 12'h014, 0);
      chk("count restart", 32'h0000_0000, rv);
      $display("test repeat done");
    end
  endtask
  task t_single;
    begin
      cfg(32'h0000_0005, 32'h0000_0001, 32'h0000_0003);
      c0 = n_clr;
      pin_source_inst.drive(1, 800);
      pin_source_inst.drive(0, 800);
      pin_source_inst.drive(1, 800);
      chk("single clears", c0 + 1, n_clr);
      chk("single sel", 32'h0000_0003, target_sel);
      xfer(0, 12'h014, 0);
      chk("single count", 32'h0000_0001, rv);
      $display("test single done");
    end
  endtask
  task t_lost_off;
    begin
      cfg(32'h0000_0001, 32'h0000_0002, 32'h0000_0007);
      c0 = n_clr;
      pin_source_inst.drive(0, 800);
      pin_source_inst.drive(1, 10);
      pin_source_inst.drive(0, 10);
      pin_source_inst.drive(1, 800);
      xfer(0, 12'h014, 0);
      chk("lost count", 32'h0000_0001, rv);
      xfer(1, 12'h000, 32'h0000_0000);
      pin_source_inst.drive(0, 800);
      pin_source_inst.drive(1, 800);
      chk("off clears", c0, n_clr);
      $display("test lost and off done");
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    n_fail = 0; n_compared = 0; n_clr = 0;
    hresetn = 1'b0; haddr = 0; hwdata = 0; htrans = 2'b00; hwrite = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_repeat;
    t_single;
    t_lost_off;
    end_sim;
  end
  // cut a hang short
  initial begin
    #(20 * 40000);
    n_fail = n_fail + 1;
    end_sim;
  end
endmodule
